// [peripheral_frame_guard.sv]
// Contract
// - Each of sixteen 16-byte peripheral frames keeps its own mapping and guard attributes.
// - Frame zero has fixed attributes that never change.
// - Writes to the attributes of the nonvolatile-memory control frame are ignored.
// - A frame mapped to the expansion board sends all its accesses to the board, which completes them.
// - A frame mapped on-chip is served by the processor's own peripheral registers.
// - A read of a read-guarded frame is flagged as a violation.
// - A write of a write-guarded frame is flagged as a violation.
// - A guarded write still reaches the register and then the CPU is halted.
// - Clear-guards drops read and write guards of the selected frames at once.
// - Idle status is high while the processor executes its wait instruction.
// - Idle status clears on interrupt acknowledge or on entering control mode.
// - Bad-instruction status rises when an invalid opcode fetch is detected.
// - Running status is high while user code executes.
`timescale 1ns/1ps
module peripheral_frame_guard
	import frame_guard_pkg::*;
#(
	parameter logic [15:0] FIXED_FRAMES = FIXED_FRAMES_DEFAULT
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire frame_guard_pkg::pf_access_t cpu_access,
	input wire frame_guard_pkg::cpu_state_t cpu_state,
	output logic expansion_sel,
	output logic onchip_sel,
	output logic violation,
	output logic cpu_halt,
	output frame_guard_pkg::status_out_t status
);
	import frame_guard_pkg::*;

	logic [15:0] fixed_frames;
	logic [15:0] map_exp;
	logic [15:0] read_guard;
	logic [15:0] write_guard;
	logic wr_access;
	logic rd_access;
	logic wr_map;
	logic wr_read_guard;
	logic wr_write_guard;
	logic wr_clear;
	logic wr_control;
	logic addr_ok;
	logic [FRAME_IDX_W-1:0] frame_idx;
	logic read_hit;
	logic write_hit;
	logic halted;
	logic [FRAME_IDX_W-1:0] violation_frame;
	access_kind_t violation_kind;
	logic [31:0] next_prdata;
	logic idle;
	logic bad_instruction;
	logic running;

	assign fixed_frames = FIXED_FRAMES | 16'h0001;

	// APB slave: zero-wait, error on unmapped offsets
	assign pready = 1'b1;
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && !pwrite;
	always_comb begin
		addr_ok = 1'b1;
		unique case (paddr)
			MAP_OFFSET, READ_GUARD_OFFSET, WRITE_GUARD_OFFSET, CLEAR_OFFSET,
			STATUS_OFFSET, VIOLATION_OFFSET, CONTROL_OFFSET: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !addr_ok;
	assign wr_map = wr_access && paddr == MAP_OFFSET;
	assign wr_read_guard = wr_access && paddr == READ_GUARD_OFFSET;
	assign wr_write_guard = wr_access && paddr == WRITE_GUARD_OFFSET;
	assign wr_clear = wr_access && paddr == CLEAR_OFFSET;
	assign wr_control = wr_access && paddr == CONTROL_OFFSET;

	frame_attr_table u_table (
		.pclk(pclk),
		.presetn(presetn),
		.fixed_frames(fixed_frames),
		.wr_map(wr_map),
		.wr_read_guard(wr_read_guard),
		.wr_write_guard(wr_write_guard),
		.wr_clear(wr_clear),
		.wdata(pwdata[15:0]),
		.map_exp(map_exp),
		.read_guard(read_guard),
		.write_guard(write_guard)
	);

	// Frame decode and routing
	assign frame_idx = cpu_access.addr[FRAME_MSB:FRAME_LSB];
	assign expansion_sel = cpu_access.valid && map_exp[frame_idx];
	assign onchip_sel = cpu_access.valid && !map_exp[frame_idx];
	assign read_hit = cpu_access.valid && !cpu_access.write && read_guard[frame_idx];
	assign write_hit = cpu_access.valid && cpu_access.write && write_guard[frame_idx];
	assign violation = read_hit || write_hit;
	assign cpu_halt = halted;

	// Halt latch; write data is not blocked
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halted <= 1'b0;
		end else if (violation) begin
			halted <= 1'b1;
		end else if (wr_control && pwdata[CTRL_RESUME_BIT]) begin
			halted <= 1'b0;
		end
	end

	// Captured violation details
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			violation_frame <= '0;
			violation_kind <= write_access;
		end else if (violation && !halted) begin
			violation_frame <= frame_idx;
			violation_kind <= write_hit ? write_access : read_access;
		end
	end

	// Idle indication
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle <= 1'b0;
		end else if (cpu_state.int_ack || cpu_state.control_mode) begin
			idle <= 1'b0;
		end else if (cpu_state.wait_exec) begin
			idle <= 1'b1;
		end
	end

	// Bad-instruction indication, held until control mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_instruction <= 1'b0;
		end else if (cpu_state.bad_fetch) begin
			bad_instruction <= 1'b1;
		end else if (cpu_state.control_mode) begin
			bad_instruction <= 1'b0;
		end
	end

	// Running indication
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
		end else begin
			running <= cpu_state.user_run;
		end
	end

	assign status = '{idle: idle, bad_instruction: bad_instruction, running: running};

	// Read data mux
	always_comb begin
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			MAP_OFFSET: next_prdata[15:0] = map_exp;
			READ_GUARD_OFFSET: next_prdata[15:0] = read_guard;
			WRITE_GUARD_OFFSET: next_prdata[15:0] = write_guard;
			STATUS_OFFSET: begin
				next_prdata[STAT_IDLE_BIT] = idle;
				next_prdata[STAT_BAD_BIT] = bad_instruction;
				next_prdata[STAT_RUN_BIT] = running;
				next_prdata[STAT_HALT_BIT] = halted;
				next_prdata[STAT_FRAME_LSB +: FRAME_IDX_W] = violation_frame;
				next_prdata[STAT_FRAME_LSB + FRAME_IDX_W] = violation_kind;
			end
			VIOLATION_OFFSET: next_prdata[FRAME_IDX_W-1:0] = violation_frame;
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_access && !penable) begin
			prdata <= next_prdata;
		end
	end

	// Checks
	sequence guarded_write_s;
		cpu_access.valid && cpu_access.write && write_guard[frame_idx];
	endsequence

	sequence halt_follow_s;
		violation ##1 cpu_halt;
	endsequence

	write_halts_a: assert property (@(posedge pclk) disable iff (!presetn)
		guarded_write_s |-> halt_follow_s) else $error("guarded write did not halt");
	read_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && !cpu_access.write && read_guard[frame_idx]) |-> violation)
		else $error("guarded read not flagged");
	unguarded_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && !read_guard[frame_idx] && !write_guard[frame_idx]) |-> !violation)
		else $error("violation without guard");
	frame_zero_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
		$stable(map_exp[0]) && $stable(read_guard[0]) && $stable(write_guard[0]))
		else $error("frame zero attributes changed");
	route_exclusive_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_access.valid |-> (expansion_sel != onchip_sel))
		else $error("frame routing not exclusive");
	clear_both_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clear |=> (((read_guard | write_guard) & $past(pwdata[15:0])) == 16'h0000))
		else $error("clear left a guard set");
	idle_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_state.int_ack || cpu_state.control_mode) |=> !status.idle)
		else $error("idle not cleared");
	idle_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_state.wait_exec && !cpu_state.int_ack && !cpu_state.control_mode) |=> status.idle)
		else $error("idle not set");
	bad_op_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_state.bad_fetch |=> status.bad_instruction) else $error("bad opcode not shown");
	run_track_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_state.user_run |=> status.running) else $error("running not shown");

	// Routing
	exp_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && map_exp[frame_idx]) |-> (expansion_sel && !onchip_sel))
		else $error("mapped frame not sent to board");

	onchip_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && !map_exp[frame_idx]) |-> (onchip_sel && !expansion_sel))
		else $error("internal frame not served on-chip");

	no_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cpu_access.valid |-> (!expansion_sel && !onchip_sel))
		else $error("routing without access");

	// Guards
	write_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && cpu_access.write && write_guard[frame_idx]) |-> violation)
		else $error("guarded write not flagged");

	read_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && !cpu_access.write && !read_guard[frame_idx]) |-> !violation)
		else $error("unguarded read flagged");

	write_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_access.valid && cpu_access.write && !write_guard[frame_idx]) |-> !violation)
		else $error("unguarded write flagged");

	violation_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
		violation |-> cpu_access.valid)
		else $error("violation without access");

	write_passes_a: assert property (@(posedge pclk) disable iff (!presetn)
		write_hit |-> (expansion_sel || onchip_sel))
		else $error("guarded write blocked");

	// Halt and capture
	sequence resume_s;
		wr_control && pwdata[CTRL_RESUME_BIT] && !violation;
	endsequence

	halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_halt && !(wr_control && pwdata[CTRL_RESUME_BIT])) |=> cpu_halt)
		else $error("halt dropped without resume");

	resume_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		resume_s |=> !cpu_halt)
		else $error("resume did not release halt");

	halt_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cpu_halt) |-> $past(violation))
		else $error("halt without violation");

	capture_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
		(violation && !cpu_halt) |=> (violation_frame == $past(frame_idx)))
		else $error("violation frame not captured");

	capture_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(read_hit && !cpu_halt) |=> (violation_kind == read_access))
		else $error("read violation kind wrong");

	capture_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(write_hit && !cpu_halt) |=> (violation_kind == write_access))
		else $error("write violation kind wrong");

	capture_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_halt |=> ($stable(violation_frame) && $stable(violation_kind)))
		else $error("capture changed while halted");

	// Attribute table
	fixed_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		(map_exp & fixed_frames) == 16'h0000)
		else $error("fixed frame mapping changed");

	fixed_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
		((read_guard | write_guard) & fixed_frames) == 16'h0000)
		else $error("fixed frame guard changed");

	map_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_map |=> (map_exp == ($past(pwdata[15:0]) & ~fixed_frames)))
		else $error("mapping write not taken");

	read_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_read_guard |=> (read_guard == ($past(pwdata[15:0]) & ~fixed_frames)))
		else $error("read guard write not taken");

	write_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_write_guard |=> (write_guard == ($past(pwdata[15:0]) & ~fixed_frames)))
		else $error("write guard write not taken");

	// Status indications
	idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(status.idle && !cpu_state.int_ack && !cpu_state.control_mode) |=> status.idle)
		else $error("idle dropped early");

	idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!status.idle && !cpu_state.wait_exec) |=> !status.idle)
		else $error("idle without wait");

	bad_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(status.bad_instruction && !cpu_state.control_mode) |=> status.bad_instruction)
		else $error("bad opcode status dropped");

	bad_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_state.control_mode && !cpu_state.bad_fetch) |=> !status.bad_instruction)
		else $error("bad opcode status not cleared");

	run_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cpu_state.user_run |=> !status.running)
		else $error("running shown while stopped");

endmodule

// [frame_guard_pkg.sv]
package frame_guard_pkg;

	localparam int FRAME_COUNT = 16;
	localparam int FRAME_IDX_W = 4;
	localparam int FRAME_LSB = 4;
	localparam int FRAME_MSB = 7;

	// APB register byte offsets
	localparam logic [7:0] MAP_OFFSET = 8'h00;
	localparam logic [7:0] READ_GUARD_OFFSET = 8'h04;
	localparam logic [7:0] WRITE_GUARD_OFFSET = 8'h08;
	localparam logic [7:0] CLEAR_OFFSET = 8'h0c;
	localparam logic [7:0] STATUS_OFFSET = 8'h10;
	localparam logic [7:0] VIOLATION_OFFSET = 8'h14;
	localparam logic [7:0] CONTROL_OFFSET = 8'h18;

	// Status register field positions
	localparam int STAT_IDLE_BIT = 0;
	localparam int STAT_BAD_BIT = 1;
	localparam int STAT_RUN_BIT = 2;
	localparam int STAT_HALT_BIT = 3;
	localparam int STAT_FRAME_LSB = 4;

	// Control register field positions
	localparam int CTRL_RESUME_BIT = 0;

	localparam logic [15:0] MAP_RESET = 16'h0000;
	localparam logic [15:0] GUARD_RESET = 16'h0000;
	localparam logic [15:0] FIXED_FRAMES_DEFAULT = 16'h0003;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} pf_access_t;

	typedef struct packed {
		logic wait_exec;
		logic int_ack;
		logic control_mode;
		logic bad_fetch;
		logic user_run;
	} cpu_state_t;

	typedef struct packed {
		logic idle;
		logic bad_instruction;
		logic running;
	} status_out_t;

	typedef enum logic [0:0] {
		write_access,
		read_access
	} access_kind_t;

endpackage

// [frame_attr_table.sv]
`timescale 1ns/1ps
module frame_attr_table
	import frame_guard_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] fixed_frames,
	input wire logic wr_map,
	input wire logic wr_read_guard,
	input wire logic wr_write_guard,
	input wire logic wr_clear,
	input wire logic [15:0] wdata,
	output logic [15:0] map_exp,
	output logic [15:0] read_guard,
	output logic [15:0] write_guard
);
	import frame_guard_pkg::*;

	genvar i;
	generate
		for (i = 0; i < FRAME_COUNT; i++) begin : g_frame
			// Per-frame attributes; fixed frames never change
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					map_exp[i] <= MAP_RESET[i];
					read_guard[i] <= GUARD_RESET[i];
					write_guard[i] <= GUARD_RESET[i];
				end else if (!fixed_frames[i]) begin
					if (wr_map) begin
						map_exp[i] <= wdata[i];
					end
					if (wr_clear && wdata[i]) begin
						read_guard[i] <= 1'b0;
						write_guard[i] <= 1'b0;
					end else begin
						if (wr_read_guard) begin
							read_guard[i] <= wdata[i];
						end
						if (wr_write_guard) begin
							write_guard[i] <= wdata[i];
						end
					end
				end
			end
		end
	endgenerate

endmodule

// [cpu_partner.sv]
`timescale 1ns/1ps
module cpu_partner
	import frame_guard_pkg::*;
(
	input wire logic pclk,
	input wire logic expansion_sel,
	output frame_guard_pkg::pf_access_t cpu_access,
	output frame_guard_pkg::cpu_state_t cpu_state,
	output int board_count
);
	initial begin
		cpu_access = '0;
		cpu_state = '0;
		board_count = 0;
	end
	// Board completes each access steered to it
	always @(posedge pclk) begin
		if (cpu_access.valid === 1'b1 && expansion_sel === 1'b1) begin
			board_count <= board_count + 1;
		end
	end
	task automatic start(input logic wr, input logic [7:0] addr);
		@(posedge pclk);
		cpu_access <= '{valid: 1'b1, write: wr, addr: addr};
		#1;
	endtask
	// Released bus shows inverted values
	task automatic stop();
		@(posedge pclk);
		cpu_access <= '{valid: 1'b0, write: ~cpu_access.write, addr: ~cpu_access.addr};
		#1;
	endtask
	task automatic set_state(input cpu_state_t s);
		@(posedge pclk);
		cpu_state <= s;
	endtask
endmodule

// [test_peripheral_frame_guard.sv]
`timescale 1ns/1ps
module test_peripheral_frame_guard;
	import frame_guard_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic err, expansion_sel, onchip_sel, violation, cpu_halt;
	pf_access_t cpu_access;
	cpu_state_t cpu_state;
	status_out_t status;
	int board_count, fails, tests_run;
	peripheral_frame_guard uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_access(cpu_access), .cpu_state(cpu_state),
		.expansion_sel(expansion_sel), .onchip_sel(onchip_sel), .violation(violation),
		.cpu_halt(cpu_halt), .status(status));
	cpu_partner cpu (.pclk(pclk), .expansion_sel(expansion_sel), .cpu_access(cpu_access),
		.cpu_state(cpu_state), .board_count(board_count));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic finish_test();
		$display("Counts: %0d compared, %0d bad", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			finish_test();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic stchk(input cpu_state_t s, input logic [2:0] exp);
		cpu.set_state(s);
		@(posedge pclk);
		#1;
		chk(status, exp);
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(MAP_OFFSET, 32'h0);
		rd(STATUS_OFFSET, 32'h0);
		$display("test reset done");
		wr(MAP_OFFSET, 32'hffffffff);
		rd(MAP_OFFSET, 32'h0000fffc);
		cpu.start(1'b0, 8'h57);
		chk({expansion_sel, onchip_sel}, 2'h2);
		cpu.start(1'b1, 8'h1a);
		chk({expansion_sel, onchip_sel}, 2'h1);
		cpu.start(1'b0, 8'h03);
		chk({expansion_sel, onchip_sel}, 2'h1);
		cpu.stop();
		chk(board_count, 32'h1);
		wr(MAP_OFFSET, 32'h0);
		$display("test mapping done");
		wr(READ_GUARD_OFFSET, 32'h00000008);
		cpu.start(1'b0, 8'h40);
		chk(violation, 1'b0);
		cpu.start(1'b0, 8'h3f);
		chk(violation, 1'b1);
		cpu.stop();
		chk(cpu_halt, 1'b1);
		rd(STATUS_OFFSET, 32'h00000138);
		wr(CONTROL_OFFSET, 32'h1);
		chk(cpu_halt, 1'b0);
		$display("test read guard done");
		wr(WRITE_GUARD_OFFSET, 32'h00000200);
		cpu.start(1'b0, 8'h90);
		chk(violation, 1'b0);
		cpu.start(1'b1, 8'h9f);
		chk({violation, onchip_sel}, 2'h3);
		cpu.stop();
		chk(cpu_halt, 1'b1);
		rd(VIOLATION_OFFSET, 32'h9);
		wr(CONTROL_OFFSET, 32'h1);
		$display("test write guard done");
		wr(READ_GUARD_OFFSET, 32'hffff);
		wr(WRITE_GUARD_OFFSET, 32'hffff);
		cpu.start(1'b0, 8'h05);
		chk(violation, 1'b0);
		cpu.stop();
		wr(CLEAR_OFFSET, 32'h0200);
		rd(READ_GUARD_OFFSET, 32'h0000fdfc);
		rd(WRITE_GUARD_OFFSET, 32'h0000fdfc);
		wr(CLEAR_OFFSET, 32'hffff);
		apb(1'b0, 8'h1c, 32'h0);
		chk(err, 1'b1);
		chk(q, 32'h0);
		$display("test clear and unmapped done");
		stchk(5'h10, 3'h4);
		stchk(5'h08, 3'h0);
		stchk(5'h10, 3'h4);
		stchk(5'h04, 3'h0);
		stchk(5'h02, 3'h2);
		stchk(5'h00, 3'h2);
		stchk(5'h04, 3'h0);
		stchk(5'h01, 3'h1);
		stchk(5'h00, 3'h0);
		$display("test status done");
		finish_test();
	end
endmodule
